// >>> core/tgs_consts.svh
`ifndef TGS_CONSTS_SVH
`define TGS_CONSTS_SVH

// Clock period of the controller clock, in nanoseconds.
`define TGS_CLK_PERIOD_NS   100
// Dropout observation interval as printed, in nanoseconds.
`define TGS_DROPOUT_TIME_NS 27000
// Observation interval in controller cycles, rounded up.
`define TGS_DROPOUT_CYCLES \
  ((`TGS_DROPOUT_TIME_NS + `TGS_CLK_PERIOD_NS - 1) / `TGS_CLK_PERIOD_NS)

// Mode control field positions and the pattern that selects the mode.
`define TGS_MODE_B7         7
`define TGS_MODE_B6         6
`define TGS_MODE_B4         4
`define TGS_MODE_B3         3
`define TGS_MODE_PATTERN    4'h4
// Channel enable field of the current registers starts at bit 5.
`define TGS_CH_LSB          5
// Number of LED channels.
`define TGS_NUM_CH          3

`endif

// >>> core/tgs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tgs_consts.svh"

// ----------------------------------------------------------------------
// Torch gain step controller
// ----------------------------------------------------------------------
module tgs_ctrl #(
  parameter int NUM_CH          = `TGS_NUM_CH,
  parameter int DROPOUT_CYCLES  = `TGS_DROPOUT_CYCLES,
  parameter int CNT_W           = 16
) (
  // Clock and synchronous reset.
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // Register contents from the bus logic, same clock domain.
  input  wire logic [7:0]        mode_control_reg_in,
  input  wire logic [7:0]        torch_current_reg_in,
  input  wire logic [7:0]        flash_current_reg_in,
  // Analog comparator flags, asynchronous.
  input  wire logic              vout_at_limit_in,
  input  wire logic              vout_sense_open_in,
  input  wire logic              vout_short_in,
  input  wire logic              temp_above_hi_in,
  input  wire logic              temp_below_lo_in,
  input  wire logic [NUM_CH-1:0] led_below_220_in,
  input  wire logic [NUM_CH-1:0] led_below_180_in,
  input  wire logic [NUM_CH-1:0] led_short_cmp_in,
  // Pump control.
  output var  logic              pump_on_out,
  output var  logic [1:0]        gain_out,
  output var  logic              vdo_sel_220_out,
  output var  logic              current_limit_out,
  output var  logic              out_disconnect_out,
  // Channel drivers and status.
  output var  logic [NUM_CH-1:0] led_en_out,
  output var  logic [NUM_CH-1:0] led_shorted_out,
  output var  logic              standby_out,
  output var  logic              thermal_off_out,
  output var  logic              hetm_active_out
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------

  // The channel field is three bits wide, so at most three channels.
  if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
    $error("NUM_CH must be 1 to 3");
  end
  // The counter must be able to hold the whole interval.
  if (DROPOUT_CYCLES < 1 || DROPOUT_CYCLES >= (2 ** CNT_W)) begin : g_bad_cnt
    $error("DROPOUT_CYCLES does not fit CNT_W");
  end

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DROPOUT_CYCLES - 1);

  logic                 at_limit_s;     // Output at its 4.5V limit.
  logic                 sense_open_s;   // Output sense pin open.
  logic                 out_short_s;    // Output shorted.
  logic                 temp_hi_s;      // Junction above upper trip.
  logic                 temp_lo_s;      // Junction below lower trip.
  logic [NUM_CH-1:0]    below_220_s;    // Pin below 220mV per channel.
  logic [NUM_CH-1:0]    below_180_s;    // Pin below 180mV per channel.
  logic [NUM_CH-1:0]    short_cmp_s;    // Output minus pin below 200mV.
  logic [NUM_CH-1:0]    ch_sel;         // Channels software asked for.
  logic [NUM_CH-1:0]    ch_live;        // Selected and not shorted.
  logic [NUM_CH-1:0]    below_sel;      // Pin below current threshold.
  logic                 mode_hit;       // Mode field holds the pattern.
  logic                 standby;        // Either channel field empty.
  logic                 run_ok;         // All conditions to run hold.
  logic                 dropout;        // Some live channel in dropout.
  logic                 cnt_done;       // Observation interval over.
  tgs_pkg::tgs_state_t  state_reg;
  tgs_pkg::tgs_state_t  state_next;
  tgs_pkg::tgs_gain_t   gain_reg;
  logic [CNT_W-1:0]     cnt_reg;

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------

  // Every comparator flag crosses two flops before any logic reads it.
  tgs_sync #(
    .W (5 + 3 * NUM_CH)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({vout_at_limit_in, vout_sense_open_in, vout_short_in,
                  temp_above_hi_in, temp_below_lo_in,
                  led_below_220_in, led_below_180_in, led_short_cmp_in}),
    .sync_out   ({at_limit_s, sense_open_s, out_short_s,
                  temp_hi_s, temp_lo_s,
                  below_220_s, below_180_s, short_cmp_s})
  );

  // --------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------

  // Only the exact pattern on bits 7, 6, 4 and 3 selects this mode.
  assign mode_hit = ({mode_control_reg_in[`TGS_MODE_B7],
                      mode_control_reg_in[`TGS_MODE_B6],
                      mode_control_reg_in[`TGS_MODE_B4],
                      mode_control_reg_in[`TGS_MODE_B3]}
                     == `TGS_MODE_PATTERN);

  // An empty channel field in either current register means standby.
  assign standby =
    (torch_current_reg_in[`TGS_CH_LSB +: 3] == 3'h0) ||
    (flash_current_reg_in[`TGS_CH_LSB +: 3] == 3'h0);

  // Channel enables come from the upper bits of the torch register.
  assign ch_sel = torch_current_reg_in[`TGS_CH_LSB +: NUM_CH];

  // Running needs the mode, a channel, no thermal trip and a sense pin.
  // The synchronised hot flag is included too, so the cycle before the
  // registered trip can never start a fresh charge.
  assign run_ok = mode_hit && !standby && !thermal_off_out && !temp_hi_s &&
                  !sense_open_s;

  // --------------------------------------------------------------------
  // Per-channel dropout selection and short handling
  // --------------------------------------------------------------------

  // Each channel is judged on its own, so a short on one never touches
  // the others. An open LED has no comparator here on purpose: it only
  // lifts its own pin, which can never start the pump.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    // Threshold follows the gain: 220mV at 1x, 180mV above.
    assign below_sel[i] = (gain_reg == tgs_pkg::TGS_GAIN_1X) ?
                          below_220_s[i] : below_180_s[i];
    // Shorted channels drop out of the dropout decision.
    assign ch_live[i] = ch_sel[i] && !led_shorted_out[i];

    // A short latches until the channel field empties; a new short in
    // the same cycle as the clear still wins.
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        led_shorted_out[i] <= 1'b0;
      end else if (short_cmp_s[i] && (state_reg == tgs_pkg::TGS_ST_REG ||
                   state_reg == tgs_pkg::TGS_ST_BOOST)) begin
        led_shorted_out[i] <= 1'b1;
      end else if (standby) begin
        led_shorted_out[i] <= 1'b0;
      end
    end
  end

  // Any live channel below its threshold calls for charge.
  assign dropout = |(below_sel & ch_live);

  // The interval ends on its last count.
  assign cnt_done = (cnt_reg == CNT_LAST);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------

  // Next-state logic; the output limit ends any pumping phase.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tgs_pkg::TGS_ST_IDLE: begin
        // Entry always begins with a charge to the limit.
        if (run_ok) begin
          state_next = tgs_pkg::TGS_ST_START;
        end
      end
      tgs_pkg::TGS_ST_START: begin
        // LEDs wait until the output has reached 4.5V.
        if (!run_ok) begin
          state_next = tgs_pkg::TGS_ST_IDLE;
        end else if (at_limit_s) begin
          state_next = tgs_pkg::TGS_ST_REG;
        end
      end
      tgs_pkg::TGS_ST_REG: begin
        // Restart only when a pin sags and the output has headroom.
        if (!run_ok) begin
          state_next = tgs_pkg::TGS_ST_IDLE;
        end else if (dropout && !at_limit_s) begin
          state_next = tgs_pkg::TGS_ST_BOOST;
        end
      end
      tgs_pkg::TGS_ST_BOOST: begin
        // Limit reached at any gain stops the pump at once.
        if (!run_ok) begin
          state_next = tgs_pkg::TGS_ST_IDLE;
        end else if (at_limit_s) begin
          state_next = tgs_pkg::TGS_ST_REG;
        end
      end
      default: begin
        state_next = tgs_pkg::TGS_ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= tgs_pkg::TGS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // Dropout observation counter
  // --------------------------------------------------------------------

  // Counts only while boosting; any other state, a gain step, or the end
  // of an interval starts it again from zero, so each gain gets a full
  // interval.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (state_next != tgs_pkg::TGS_ST_BOOST ||
                 state_reg != tgs_pkg::TGS_ST_BOOST || cnt_done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // --------------------------------------------------------------------
  // Gain control
  // --------------------------------------------------------------------

  // Gain starts at 1x on each entry, climbs one step per failed
  // interval and stays at 2x once there. An output short pins it to
  // 1x, which is also the only gain with the hard current limit.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      gain_reg <= tgs_pkg::TGS_GAIN_1X;
    end else if (out_short_s) begin
      gain_reg <= tgs_pkg::TGS_GAIN_1X;
    end else if (state_reg == tgs_pkg::TGS_ST_IDLE) begin
      gain_reg <= tgs_pkg::TGS_GAIN_1X;
    end else if (state_reg == tgs_pkg::TGS_ST_BOOST &&
                 state_next == tgs_pkg::TGS_ST_BOOST &&
                 cnt_done && dropout) begin
      case (gain_reg)
        tgs_pkg::TGS_GAIN_1X: begin
          gain_reg <= tgs_pkg::TGS_GAIN_15X;
        end
        tgs_pkg::TGS_GAIN_15X: begin
          gain_reg <= tgs_pkg::TGS_GAIN_2X;
        end
        default: begin
          gain_reg <= tgs_pkg::TGS_GAIN_2X;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Thermal hysteresis
  // --------------------------------------------------------------------

  // Trip above the upper threshold, release only below the lower one;
  // between them the flag holds, which stops chatter at the trip point.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      thermal_off_out <= 1'b0;
    end else if (temp_hi_s) begin
      thermal_off_out <= 1'b1;
    end else if (temp_lo_s) begin
      thermal_off_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------

  // Pump runs while charging up or boosting, never at the limit.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pump_on_out <= 1'b0;
    end else begin
      pump_on_out <= (state_next == tgs_pkg::TGS_ST_START ||
                      state_next == tgs_pkg::TGS_ST_BOOST) &&
                     !at_limit_s;
    end
  end

  // Gain and threshold selection mirror the gain register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      gain_out        <= 2'h0;
      vdo_sel_220_out <= 1'b1;
    end else begin
      gain_out        <= gain_reg;
      vdo_sel_220_out <= (gain_reg == tgs_pkg::TGS_GAIN_1X);
    end
  end

  // Fault responses: open sense disconnects, short limits current.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      out_disconnect_out <= 1'b0;
      current_limit_out  <= 1'b0;
    end else begin
      out_disconnect_out <= sense_open_s;
      current_limit_out  <= out_short_s;
    end
  end

  // Drivers are on only while regulating or boosting, for selected healthy channels.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      led_en_out <= '0;
    end else if (state_next == tgs_pkg::TGS_ST_REG ||
                 state_next == tgs_pkg::TGS_ST_BOOST) begin
      led_en_out <= ch_sel & ~led_shorted_out &
                    ~(short_cmp_s & ch_sel);
    end else begin
      led_en_out <= '0;
    end
  end

  // Status flags.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      standby_out     <= 1'b0;
      hetm_active_out <= 1'b0;
    end else begin
      standby_out     <= standby;
      hetm_active_out <= (state_next != tgs_pkg::TGS_ST_IDLE);
    end
  end

endmodule

`default_nettype wire

// >>> core/tgs_pkg.sv
package tgs_pkg;

  // Charge pump gain.
  typedef enum logic [1:0] {
    TGS_GAIN_1X  = 2'h0,
    TGS_GAIN_15X = 2'h1,
    TGS_GAIN_2X  = 2'h2
  } tgs_gain_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    TGS_ST_IDLE  = 2'h0,
    TGS_ST_START = 2'h1,
    TGS_ST_REG   = 2'h2,
    TGS_ST_BOOST = 2'h3
  } tgs_state_t;

endpackage

// >>> core/tgs_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-stage synchroniser for comparator levels
// ----------------------------------------------------------------------
module tgs_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [W-1:0] meta_reg;

  // Both stages reset low so no fault is seen before the first sample.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// >>> dv/test_torch_gain_step_controller.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the torch gain step controller
// ------------------------------------------------------------
module test_torch_gain_step_controller;
  localparam int D = 6;  // Shortened dropout interval keeps the run brief.
  logic clk, rst, sense_open, out_short, temp_hi, temp_lo, sag, stall;
  logic [7:0] mode_reg, torch_reg, flash_reg;
  logic [2:0] short_cmp, b220, b180, led_en, shorted;
  logic at_limit, pump_on, vdo220, cur_lim, disc, standby, therm, hetm;
  logic [1:0] gain;
  int errors, n_tests, n;

  tgs_ctrl #(.DROPOUT_CYCLES(D)) dut (
    .clk_sys_in(clk), .rst_in(rst), .mode_control_reg_in(mode_reg),
    .torch_current_reg_in(torch_reg), .flash_current_reg_in(flash_reg),
    .vout_at_limit_in(at_limit), .vout_sense_open_in(sense_open), .vout_short_in(out_short),
    .temp_above_hi_in(temp_hi), .temp_below_lo_in(temp_lo), .led_below_220_in(b220),
    .led_below_180_in(b180), .led_short_cmp_in(short_cmp), .pump_on_out(pump_on),
    .gain_out(gain), .vdo_sel_220_out(vdo220), .current_limit_out(cur_lim),
    .out_disconnect_out(disc), .led_en_out(led_en), .led_shorted_out(shorted),
    .standby_out(standby), .thermal_off_out(therm), .hetm_active_out(hetm));

  tgs_pump_model u_pump (
    .clk_sys_in(clk), .rst_in(rst), .pump_on_in(pump_on), .sag_in(sag), .stall_in(stall),
    .at_limit_out(at_limit), .below_220_out(b220), .below_180_out(b180));

  // Inputs always move a fixed delay after the rising edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  // Compare two values with case equality so unknowns never match.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait on the pump (sel 0) or the gain (sel 1); n returns the cycles spent.
  task automatic wait_on(input bit sel, input logic [1:0] v, output int cnt);
    cnt = 0;
    while ((sel ? gain : {1'b0, pump_on}) !== v) begin
      cyc(1);
      cnt++;
      if (cnt > 400) begin
        errors++;
        $display("[FAIL] %0t wait ran out", $time);
        complete_run();
      end
    end
  endtask

  // Only the single pattern of the four mode bits may start the sequence.
  task automatic test_mode();
    for (int i = 0; i < 16; i++) begin
      mode_reg = {i[3], i[2], 1'b0, i[1], i[0], 3'h0};
      cyc(4);
      chk({7'h0, hetm}, {7'h0, i == 4}, "mode select");
      mode_reg = 8'h00;
      cyc(4);
    end
    $display("test_mode done");
  endtask

  // Charge to the limit first, then light only the selected channels.
  task automatic test_start();
    mode_reg = 8'h40;
    torch_reg = 8'ha0;
    wait_on(1'b0, 2'h1, n);
    wait_on(1'b0, 2'h0, n);
    cyc(3);
    chk({7'h0, at_limit}, 8'h01, "stopped at limit");
    chk({5'h0, led_en}, 8'h05, "channels lit");
    $display("test_start done");
  endtask

  // A stalled pump with low pins must climb one gain per full interval and stop at 2x.
  task automatic test_step();
    sag = 1'b1;
    stall = 1'b1;
    wait_on(1'b0, 2'h1, n);
    wait_on(1'b1, 2'h1, n);
    chk({7'h0, n >= D - 1 && n <= D + 4}, 8'h01, "first step time");
    chk({7'h0, vdo220}, 8'h00, "threshold at 1.5x");
    wait_on(1'b1, 2'h2, n);
    chk({7'h0, n >= D - 1 && n <= D + 4}, 8'h01, "second step time");
    cyc(3 * D);
    chk({6'h0, gain}, 8'h02, "gain held at 2x");
    out_short = 1'b1;
    cyc(5);
    chk({5'h0, cur_lim, gain}, 8'h04, "short pulls gain to 1x");
    out_short = 1'b0;
    sag = 1'b0;
    stall = 1'b0;
    wait_on(1'b0, 2'h0, n);
    $display("test_step done");
  endtask

  // A shorted channel drops alone and stays flagged until standby.
  task automatic test_led_short();
    short_cmp = 3'h1;
    cyc(5);
    chk({5'h0, shorted}, 8'h01, "short flag");
    chk({5'h0, led_en}, 8'h04, "others still lit");
    short_cmp = 3'h0;
    cyc(4);
    chk({5'h0, shorted}, 8'h01, "short flag sticky");
    torch_reg = 8'h00;
    cyc(4);
    chk({4'h0, standby, led_en}, 8'h08, "standby");
    chk({5'h0, shorted}, 8'h00, "flag cleared");
    torch_reg = 8'ha0;
    $display("test_led_short done");
  endtask

  // Output short, open sense and thermal shutdown with its hysteresis.
  task automatic test_faults();
    out_short = 1'b1;
    cyc(5);
    chk({5'h0, cur_lim, gain}, 8'h04, "output short");
    out_short = 1'b0;
    sense_open = 1'b1;
    cyc(5);
    chk({6'h0, disc, hetm}, 8'h02, "open sense");
    sense_open = 1'b0;
    temp_hi = 1'b1;
    temp_lo = 1'b0;
    cyc(5);
    chk({7'h0, therm}, 8'h01, "hot shutdown");
    temp_hi = 1'b0;
    cyc(5);
    chk({7'h0, therm}, 8'h01, "inside hysteresis");
    temp_lo = 1'b1;
    cyc(5);
    chk({7'h0, therm}, 8'h00, "cooled down");
    $display("test_faults done");
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Free-running controller clock, 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence: reset for five cycles, then the scenarios in order.
  initial begin
    {errors, n_tests, n} = '0;
    {rst, sense_open, out_short, temp_hi, sag, stall} = 6'h20;
    temp_lo = 1'b1;
    {mode_reg, torch_reg, flash_reg, short_cmp} = {8'h00, 8'ha0, 8'he0, 3'h0};
    repeat (5) @(posedge clk);
    #10;
    rst = 1'b0;
    test_mode();
    test_start();
    test_step();
    test_led_short();
    test_faults();
    complete_run();
  end
endmodule

`default_nettype wire

// >>> dv/tgs_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the torch gain step controller
// ------------------------------------------------------------
module tgs_ctrl_checker #(
  parameter int NUM_CH = 3
) (
  // Clock and reset.
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  // Stimulus seen by the controller.
  input wire logic [7:0]        mode_control_reg_in,
  input wire logic [7:0]        torch_current_reg_in,
  input wire logic              vout_at_limit_in,
  input wire logic              vout_sense_open_in,
  input wire logic              vout_short_in,
  input wire logic              temp_above_hi_in,
  // Controller outputs.
  input wire logic              pump_on_out,
  input wire logic [1:0]        gain_out,
  input wire logic              vdo_sel_220_out,
  input wire logic              current_limit_out,
  input wire logic              out_disconnect_out,
  input wire logic [NUM_CH-1:0] led_en_out,
  input wire logic [NUM_CH-1:0] led_shorted_out,
  input wire logic              standby_out,
  input wire logic              thermal_off_out,
  input wire logic              hetm_active_out
);
  // High when the mode register selects the efficient torch sequence.
  logic mode_hit;

  assign mode_hit = {mode_control_reg_in[7], mode_control_reg_in[6],
                     mode_control_reg_in[4], mode_control_reg_in[3]} == 4'h4;

  // All checks share the controller clock and its synchronous reset.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  // Five samples cover the two synchroniser stages and the output flop.
  a_pump_stop_limit: assert property (vout_at_limit_in [*5] |-> !pump_on_out)
    else $error("pump still on with output at limit");
  a_gain_step_one: assert property (gain_out != $past(gain_out) |->
    (gain_out == $past(gain_out) + 2'h1) || (gain_out == 2'h0))
    else $error("gain moved other than one step up or back to 1x");
  a_vdo_follows_gain: assert property ($stable(gain_out) && $stable(vdo_sel_220_out)
    |-> vdo_sel_220_out == (gain_out == 2'h0))
    else $error("dropout threshold does not match gain");
  a_mode_gates_seq: assert property (!mode_hit [*3] |-> !hetm_active_out && !pump_on_out)
    else $error("sequence active without the mode pattern");
  a_standby_leds_off: assert property ((torch_current_reg_in[7:5] == 3'h0) [*3]
    |-> standby_out && (led_en_out == '0))
    else $error("empty channel field without standby");
  a_short_forces_1x: assert property (vout_short_in [*5]
    |-> current_limit_out && (gain_out == 2'h0))
    else $error("output short without 1x and current limit");
  a_open_disconnects: assert property (vout_sense_open_in [*5]
    |-> out_disconnect_out && !pump_on_out)
    else $error("open sense without output disconnect");
  a_hot_shutdown: assert property (temp_above_hi_in [*5]
    |-> thermal_off_out && !pump_on_out && !hetm_active_out)
    else $error("hot junction without shutdown");
  a_shorted_driver_off: assert property ((led_shorted_out & led_en_out) == '0)
    else $error("shorted channel driver still enabled");
  a_leds_in_field: assert property ($stable(torch_current_reg_in)
    |-> (led_en_out & ~torch_current_reg_in[7:5]) == '0)
    else $error("channel enabled outside the selected field");
endmodule

bind tgs_ctrl tgs_ctrl_checker #(.NUM_CH(NUM_CH)) u_checker (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_control_reg_in(mode_control_reg_in),
  .torch_current_reg_in(torch_current_reg_in), .vout_at_limit_in(vout_at_limit_in),
  .vout_sense_open_in(vout_sense_open_in), .vout_short_in(vout_short_in),
  .temp_above_hi_in(temp_above_hi_in), .pump_on_out(pump_on_out), .gain_out(gain_out),
  .vdo_sel_220_out(vdo_sel_220_out), .current_limit_out(current_limit_out),
  .out_disconnect_out(out_disconnect_out), .led_en_out(led_en_out),
  .led_shorted_out(led_shorted_out), .standby_out(standby_out),
  .thermal_off_out(thermal_off_out), .hetm_active_out(hetm_active_out)
);

`default_nettype wire

// >>> dv/tgs_pump_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Behavioural pump, output capacitor and LED pin comparators
// ------------------------------------------------------------
module tgs_pump_model #(
  parameter int LIM = 8
) (
  // Clock, reset and pump command from the controller.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       pump_on_in,
  // Load conditions commanded by the bench.
  input  wire logic       sag_in,
  input  wire logic       stall_in,
  // Comparator flags back to the controller.
  output var  logic       at_limit_out,
  output var  logic [2:0] below_220_out,
  output var  logic [2:0] below_180_out
);
  // Output voltage in coarse steps; LIM stands for the torch limit.
  logic [7:0] level_reg;

  // The pump charges unless stalled by a heavy load; a sagging load drains the cap while the pump is off.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      level_reg <= 8'h00;
    end else if (pump_on_in && !stall_in && (level_reg < 8'(LIM))) begin
      level_reg <= level_reg + 8'h01;
    end else if (!pump_on_in && sag_in && (level_reg != 8'h00)) begin
      level_reg <= level_reg - 8'h01;
    end
  end

  // Limit comparator trips at the fixed torch limit level.
  assign at_limit_out = (level_reg >= 8'(LIM));
  // A sagging load pulls every pin below both thresholds.
  assign below_220_out = {3{sag_in}};
  assign below_180_out = {3{sag_in}};
endmodule

`default_nettype wire
